//--- rtl/sacp_conv_port.v
// Purpose: Conversion control and serial data port of a SAR converter
// Assumes: Host drives convert_start, serial clock and serial_in_line
// Notes: Result word comes from the converter core at end of conversion
// How it works
// - Convert-start rising starts conversion, releases output, ignores serial input.
// - A started conversion always runs to its end.
// - Convert-start high at end selects no-busy mode, low selects busy.
// - No-busy: convert-start falling after end drives result MSB.
// - Configuration write and result read may share one access.
// - First 14 rising clock edges sample a new configuration word.
// - No-busy: first 15 falling edges shift bits from MSB-1 downward.
// - Busy: first 16 falling edges shift the result from MSB.
// - Partial configuration words are dropped at end of conversion.
// - Unread result is lost at next end; new MSB presented.
// - Output bits stay stable across both serial clock edges.
// - No-busy: release at 16th or 30th fall, or convert-start rise.
// - Readback sends configuration MSB first after result LSB.
// - Busy with readback releases after 31 falling edges.
// - Busy: output goes low at end of conversion as busy edge.
// - Busy: release at 17th or 31st fall, or convert-start rise.
// - Readback-suppress bit zero enables readback, one suppresses it.
`timescale 1ns/100ps
`default_nettype none
`include "sacp_regs.vh"

module sacp_conv_port #(
  parameter RES_W = `SACP_RES_W,
  parameter CFG_W = `SACP_CFG_W,
  parameter CONV_CYCLES = `SACP_CONV_CYC,
  parameter DATA_CYCLES = `SACP_DATA_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Host pins
  input wire convertStart,
  input wire serialClk,
  input wire serialInLine,
  output reg serialOutLineO,
  output reg serialOutLineOe,
  // Converter core side
  input wire [RES_W-1:0] resultIn,
  output reg convBusy,
  output reg [CFG_W-1:0] cfgWord
);

  // Output states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ARMED = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;

  localparam integer FRAME_W = `SACP_FRAME_W;
  localparam [7:0] CONV_LAST = CONV_CYCLES[7:0] - 8'h01;
  localparam [7:0] DATA_LAST = DATA_CYCLES[7:0];
  localparam [3:0] CFG_LAST = CFG_W[3:0] - 4'h1;
  localparam [3:0] CFG_FULL = CFG_W[3:0];
  localparam [4:0] FRAME_TOP = FRAME_W[4:0] - 5'h01;

  // Synchronised pins and previous levels
  wire [2:0] pinSync;
  wire cnvS;
  wire sckS;
  wire sdiS;
  reg cnvPrevQ;
  reg sckPrevQ;

  // Conversion timing
  reg [7:0] convCntQ;
  wire eoc;
  wire windowOpen;

  // Configuration input
  reg [CFG_W-1:0] cfgShQ;
  reg [3:0] cfgCntQ;
  wire sdiAccept;

  // Output framing
  reg [1:0] stateQ;
  reg [1:0] stateD;
  reg [`SACP_FRAME_W-1:0] frameQ;
  reg modeBusyQ;
  reg readbackQ;
  reg [4:0] fallsQ;
  reg [4:0] fallsD;
  reg sdoD;
  reg oeD;
  reg [4:0] totalFalls;
  reg [4:0] posNext;
  reg [4:0] bitIdx;

  wire cnvRise;
  wire cnvFall;
  wire sckRise;
  wire sckFall;

  // Pin synchroniser for convert, clock and data
  sacp_sync #(
    .WIDTH(3)
  ) uSync (
    .refClk(ref_clk),
    .rst(rst),
    .asyncIn({convertStart, serialClk, serialInLine}),
    .syncOut(pinSync)
  );

  assign cnvS = pinSync[2];
  assign sckS = pinSync[1];
  assign sdiS = pinSync[0];

  // Edge detection on synchronised levels
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnvPrevQ <= 1'b0;
      sckPrevQ <= 1'b0;
    end
    else
    begin
      cnvPrevQ <= cnvS;
      sckPrevQ <= sckS;
    end
  end

  assign cnvRise = cnvS & ~cnvPrevQ;
  assign cnvFall = ~cnvS & cnvPrevQ;
  assign sckRise = sckS & ~sckPrevQ;
  assign sckFall = ~sckS & sckPrevQ;

  // End of conversion and safe data window
  assign eoc = convBusy && (convCntQ == CONV_LAST);
  assign windowOpen = ~convBusy || (convCntQ < DATA_LAST);

  // Conversion timer; level of convert-start ignored while busy
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      convBusy <= 1'b0;
      convCntQ <= 8'h00;
    end
    else if (convBusy)
    begin
      if (eoc)
      begin
        convBusy <= 1'b0;
      end
      convCntQ <= convCntQ + 8'h01;
    end
    else if (cnvRise)
    begin
      convBusy <= 1'b1;
      convCntQ <= 8'h00;
    end
  end

  // Serial input taken only while convert-start low and window open
  assign sdiAccept = ~cnvS & windowOpen;

  // Configuration shift-in on rising clock edges
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfgShQ <= {CFG_W{1'b0}};
      cfgCntQ <= 4'h0;
      cfgWord <= `SACP_CFG_RESET;
    end
    else if (eoc)
    begin
      cfgCntQ <= 4'h0;
    end
    else if (sckRise && sdiAccept && (cfgCntQ < CFG_FULL))
    begin
      cfgShQ <= {cfgShQ[CFG_W-2:0], sdiS};
      cfgCntQ <= cfgCntQ + 4'h1;
      if (cfgCntQ == CFG_LAST)
      begin
        cfgWord <= {cfgShQ[CFG_W-2:0], sdiS};
      end
    end
  end

  // Falls needed before release, per mode and readback
  always @*
  begin
    totalFalls = `SACP_NOBUSY_FALLS;
    if (modeBusyQ)
    begin
      totalFalls = readbackQ ? `SACP_BUSY_RB_FALLS : `SACP_BUSY_FALLS;
    end
    else
    begin
      totalFalls = readbackQ ? `SACP_NOBUSY_RB_FALLS : `SACP_NOBUSY_FALLS;
    end
  end

  // Output next state
  always @*
  begin
    stateD = stateQ;
    fallsD = fallsQ;
    sdoD = serialOutLineO;
    oeD = serialOutLineOe;
    posNext = 5'h00;
    bitIdx = 5'h00;
    case (stateQ)
      ST_IDLE:
      begin
        oeD = 1'b0;
      end
      ST_ARMED:
      begin
        if (cnvFall)
        begin
          stateD = ST_SHIFT;
          fallsD = 5'h00;
          sdoD = frameQ[FRAME_TOP];
          oeD = 1'b1;
        end
      end
      ST_SHIFT:
      begin
        if (sckFall)
        begin
          fallsD = fallsQ + 5'h01;
          if (fallsD == totalFalls)
          begin
            stateD = ST_IDLE;
            oeD = 1'b0;
          end
          else
          begin
            // Busy mode lags one bit behind no-busy mode
            posNext = modeBusyQ ? (fallsD - 5'h01) : fallsD;
            bitIdx = FRAME_TOP - posNext;
            sdoD = frameQ[bitIdx];
          end
        end
      end
      default:
      begin
        stateD = ST_IDLE;
        oeD = 1'b0;
      end
    endcase
    // Convert-start rise releases the output
    if (cnvRise)
    begin
      stateD = ST_IDLE;
      oeD = 1'b0;
    end
    // End of conversion reloads the frame and selects mode
    if (eoc)
    begin
      fallsD = 5'h00;
      if (cnvS)
      begin
        stateD = ST_ARMED;
        oeD = 1'b0;
      end
      else
      begin
        stateD = ST_SHIFT;
        sdoD = 1'b0;
        oeD = 1'b1;
      end
    end
  end

  // Output registers; released after reset until first end
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      stateQ <= ST_IDLE;
      fallsQ <= 5'h00;
      serialOutLineO <= 1'b0;
      serialOutLineOe <= 1'b0;
      frameQ <= {`SACP_FRAME_W{1'b0}};
      modeBusyQ <= 1'b0;
      readbackQ <= 1'b0;
    end
    else
    begin
      stateQ <= stateD;
      fallsQ <= fallsD;
      serialOutLineO <= sdoD;
      serialOutLineOe <= oeD;
      if (eoc)
      begin
        frameQ <= {resultIn, cfgWord};
        modeBusyQ <= ~cnvS;
        readbackQ <= ~cfgWord[`SACP_CFG_RB_BIT];
      end
    end
  end

endmodule

`default_nettype wire

//--- rtl/sacp_regs.vh
// Purpose: Shared constants of the serial conversion port
// Assumes: Core clock of 20 MHz
// Notes: Times are in ns, cycle counts derive from them
`ifndef SACP_REGS_VH
`define SACP_REGS_VH

// Core clock period
`define SACP_CLK_PERIOD_NS 50

// Word widths
`define SACP_RES_W 16
`define SACP_CFG_W 14
`define SACP_FRAME_W 30

// Configuration reset value and readback-suppress position
`define SACP_CFG_RESET 14'h3FFF
`define SACP_CFG_RB_BIT 0

// Conversion time, rounded up to whole cycles
`define SACP_CONV_TIME_NS 1000
`define SACP_CONV_CYC ((`SACP_CONV_TIME_NS + `SACP_CLK_PERIOD_NS - 1) / `SACP_CLK_PERIOD_NS)

// Safe data window into a conversion, rounded down
`define SACP_DATA_TIME_NS 600
`define SACP_DATA_CYC (`SACP_DATA_TIME_NS / `SACP_CLK_PERIOD_NS)

// Falling clock edges until the output is released
`define SACP_NOBUSY_FALLS 5'h10
`define SACP_NOBUSY_RB_FALLS 5'h1E
`define SACP_BUSY_FALLS 5'h11
`define SACP_BUSY_RB_FALLS 5'h1F

`endif

//--- rtl/sacp_sync.v
// Purpose: Two-stage synchroniser for pins entering the core clock
// Assumes: Inputs are asynchronous to refClk
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none

module sacp_sync #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input wire refClk,
  input wire rst,
  // Asynchronous in, synchronised out
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1Q;

  // Two flip-flops in series
  always @(posedge refClk)
  begin
    if (rst)
    begin
      stage1Q <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1Q <= asyncIn;
      syncOut <= stage1Q;
    end
  end

endmodule

`default_nettype wire

//--- tb/sacp_port_chk.sv
// Purpose: Port checker of the conversion port
// Assumes: Bench holds convertStart steady near end of conversion
// Notes: Pin latency is three core cycles
`timescale 1ns/100ps
`default_nettype none
module sacp_port_chk (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Pin and status
  input wire convertStart,
  input wire serialOutLineO,
  input wire serialOutLineOe,
  input wire convBusy
);
  // One clock domain
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Conversion and output checks
  a_busy_len: assert property (
    $rose(convBusy) |-> convBusy[*8] ##1 convBusy[*8] ##1 convBusy[*4] ##1 !convBusy)
    else $error("busy length");
  a_busy_start: assert property (
    $rose(convertStart) && !convBusy |-> ##[2:6] convBusy) else $error("no start");
  a_start_hiz: assert property (
    $rose(convBusy) |-> !serialOutLineOe[*4]) else $error("driven in conversion");
  a_busy_edge: assert property (
    $fell(convBusy) && !convertStart |-> serialOutLineOe && !serialOutLineO) else $error("no busy edge");
  a_nobusy_arm: assert property (
    $fell(convBusy) && convertStart |-> !serialOutLineOe) else $error("driven when armed");
  a_cnv_release: assert property (
    $rose(convertStart) |-> ##[1:6] !serialOutLineOe) else $error("no release");
  a_oe_cause: assert property (
    $rose(serialOutLineOe) |-> $past(convBusy) || !convertStart) else $error("drive no cause");
  a_busy_hold: assert property (
    $fell(convBusy) && serialOutLineOe |=> (serialOutLineOe && !serialOutLineO)[*3])
    else $error("busy low lost");
endmodule
bind sacp_conv_port sacp_port_chk sacp_port_chk_inst (
  .ref_clk(ref_clk), .rst(rst), .convertStart(convertStart), .serialOutLineO(serialOutLineO),
  .serialOutLineOe(serialOutLineOe), .convBusy(convBusy));
`default_nettype wire

//--- tb/sacp_host_model.sv
// Purpose: Host model driving serial clock and data in
// Assumes: Bench drives convert-start itself
// Notes: Serial clock idles low between frames
`timescale 1ns/100ps
`default_nettype none
module sacp_host_model (
  // Serial pins
  output logic serialClk,
  output logic serialInLine,
  input wire logic serialOutLine,
  // Bits seen at rising and falling clock edges
  output logic [31:0] riseBits,
  output logic [31:0] fallBits
);
  // Idle levels
  initial
  begin
    serialClk = 1'b0;
    serialInLine = 1'b0;
  end
  // Frame of n clocks, first w rises carry cfg MSB first
  task automatic frame(input int n, input logic [13:0] cfg, input int w);
    #13;
    for (int i = 0; i < n; i++)
    begin
      serialInLine = (i < w) ? cfg[13 - i] : ~serialInLine;
      #200 serialClk = 1'b1;
      riseBits = {riseBits[30:0], serialOutLine};
      #200 fallBits = {fallBits[30:0], serialOutLine};
      serialClk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- tb/test_sacp_conv_port.sv
// Purpose: Self-checking bench of the conversion port
// Assumes: Default conversion and data window lengths
// Notes: Output line has a pull-up
`timescale 1ns/100ps
`default_nettype none
`define SACP_CHK(name, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("mismatch %s expected %h seen %h", name, exp, got); \
    end \
  end
module test_sacp_conv_port;
  logic ref_clk, rst, convertStart;
  logic [15:0] resultIn;
  wire serialClk, serialInLine, outData, outEn, convBusy, serialOutLine;
  wire [13:0] cfgWord;
  wire [31:0] riseBits, fallBits;
  int bad_count = 0;
  int tests_run = 0;
  // Pull-up when released
  assign serialOutLine = outEn ? outData : 1'b1;
  sacp_conv_port sacp_conv_port_inst (
    .ref_clk(ref_clk), .rst(rst), .convertStart(convertStart), .serialClk(serialClk),
    .serialInLine(serialInLine), .serialOutLineO(outData), .serialOutLineOe(outEn),
    .resultIn(resultIn), .convBusy(convBusy), .cfgWord(cfgWord));
  sacp_host_model sacp_host_model_inst (
    .serialClk(serialClk), .serialInLine(serialInLine), .serialOutLine(serialOutLine),
    .riseBits(riseBits), .fallBits(fallBits));
  // Core clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic close_out;
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic run_frame(input int n, input logic [13:0] cfg, input int w);
    sacp_host_model_inst.frame(n, cfg, w);
    ticks(6);
  endtask
  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 200 && convBusy !== lvl; i++)
      ticks(1);
    if (convBusy !== lvl)
    begin
      bad_count++;
      close_out();
    end
  endtask
  // Conversion; level held at its end picks the mode
  task automatic convert(input logic hold, input logic [15:0] res);
    resultIn = res;
    convertStart = 1'b1;
    wait_busy(1'b1);
    ticks(2);
    convertStart = hold;
    wait_busy(1'b0);
    ticks(2);
  endtask
  task automatic t_nobusy;
    `SACP_CHK("oe", 1'b0, outEn)
    `SACP_CHK("cfg", 14'h3FFF, cfgWord)
    convert(1'b1, 16'hA5C3);
    `SACP_CHK("armed", 1'b0, outEn)
    convertStart = 1'b0;
    ticks(6);
    `SACP_CHK("msb", 1'b1, outData)
    run_frame(16, 14'h2A52, 14);
    `SACP_CHK("result", 16'hA5C3, riseBits[15:0])
    `SACP_CHK("end oe", 1'b0, outEn)
    `SACP_CHK("cfg", 14'h2A52, cfgWord)
  endtask
  task automatic t_busy;
    convert(1'b0, 16'h5B3C);
    `SACP_CHK("busy", 2'h2, {outEn, outData})
    run_frame(30, 14'h2A52, 14);
    `SACP_CHK("held oe", 1'b1, outEn)
    run_frame(1, 14'h0000, 0);
    `SACP_CHK("late oe", 1'b0, outEn)
    `SACP_CHK("stream", {1'b0, 16'h5B3C, 14'h2A52}, riseBits[30:0])
    `SACP_CHK("fall", riseBits, fallBits)
  endtask
  task automatic t_partial;
    convert(1'b0, 16'h3C3C);
    run_frame(5, 14'h0000, 5);
    convert(1'b0, 16'h0FF0);
    `SACP_CHK("kept cfg", 14'h2A52, cfgWord)
    run_frame(14, 14'h1235, 14);
    `SACP_CHK("new cfg", 14'h1235, cfgWord)
  endtask
  task automatic t_early;
    convert(1'b1, 16'hC001);
    convertStart = 1'b0;
    run_frame(4, 14'h1235, 4);
    resultIn = 16'h8E71;
    convertStart = 1'b1;
    ticks(6);
    `SACP_CHK("release", 1'b0, outEn)
    `SACP_CHK("part read", 4'hC, riseBits[3:0])
    convertStart = 1'b0;
    ticks(2);
    convertStart = 1'b1;
    wait_busy(1'b0);
    ticks(2);
    convertStart = 1'b0;
    ticks(6);
    run_frame(16, 14'h1235, 14);
    `SACP_CHK("new result", 16'h8E71, riseBits[15:0])
    `SACP_CHK("no readback", 1'b0, outEn)
  endtask
  // Reset, then scenarios
  initial
  begin
    rst = 1'b1;
    convertStart = 1'b0;
    resultIn = 16'h0000;
    ticks(16);
    rst = 1'b0;
    ticks(3);
    t_nobusy();
    t_busy();
    t_partial();
    t_early();
    close_out();
  end
endmodule
`default_nettype wire
